// *** ssrl_regs.svh ***
// latch codes, field positions and sizes for the serial synth register load block
`ifndef SSRL_REGS_SVH
`define SSRL_REGS_SVH

`define SSRL_WORD_W 32
`define SSRL_NUM_LATCH 6
`define SSRL_DEST_W 3
`define SSRL_DEST_L0 3'h0
`define SSRL_DEST_L1 3'h1
`define SSRL_DEST_L2 3'h2
`define SSRL_DEST_L3 3'h3
`define SSRL_DEST_L4 3'h4
`define SSRL_DEST_L5 3'h5
`define SSRL_LATCH_RESET 32'h0000_0000

`define SSRL_INT_W 16
`define SSRL_FRACTION_NUMERATOR_W 12
`define SSRL_RCNT_W 10
`define SSRL_CP_W 3
`define SSRL_DIV_W 3
`define SSRL_MUX_W 3
`define SSRL_PWR_W 2

`define SSRL_L0_INT_LSB 15
`define SSRL_L0_FRACTION_NUMERATOR_LSB 3
`define SSRL_L1_PRESC_BIT 27
`define SSRL_L1_PHASE_LSB 15
`define SSRL_L1_MOD_LSB 3
`define SSRL_L2_MUX_LSB 26
`define SSRL_L2_DBL_BIT 25
`define SSRL_L2_HALF_BIT 24
`define SSRL_L2_RCNT_LSB 14
`define SSRL_L2_DBUF_BIT 13
`define SSRL_L2_CP_LSB 9
`define SSRL_L2_LDF_BIT 8
`define SSRL_L4_DIV_LSB 20
`define SSRL_L4_MUTE_UNTIL_LOCK_BIT 10
`define SSRL_L4_OUTEN_BIT 5
`define SSRL_L4_PWR_LSB 3

`define SSRL_SYNC_STAGES 2

`endif

// *** ssrl_pkg.sv ***
// types shared by the serial synth register load block
`include "ssrl_regs.svh"
package ssrl_pkg;

    typedef struct packed {
        logic [`SSRL_WORD_W-`SSRL_DEST_W-1:0] payload;
        logic [`SSRL_DEST_W-1:0] dest;
    } ssrl_word_t;

    typedef struct packed {
        logic [`SSRL_FRACTION_NUMERATOR_W-1:0] phase;
        logic [`SSRL_FRACTION_NUMERATOR_W-1:0] modulus;
        logic ref_doubler;
        logic ref_halve;
        logic [`SSRL_RCNT_W-1:0] ref_count;
        logic [`SSRL_CP_W-1:0] cp_current;
    } ssrl_dbuf_t;

    typedef struct packed {
        logic [`SSRL_INT_W-1:0] int_value;
        logic [`SSRL_FRACTION_NUMERATOR_W-1:0] fraction_numerator;
        logic prescaler_89;
        ssrl_dbuf_t dbuf;
        logic [`SSRL_MUX_W-1:0] mux_sel;
        logic lock_detect_function;
        logic [`SSRL_DIV_W-1:0] out_div_sel;
        logic [`SSRL_PWR_W-1:0] out_power;
        logic out_enable;
        logic mute_until_lock;
    } ssrl_cfg_t;

endpackage : ssrl_pkg

// *** ssrl_serial_rx.sv ***
// three-wire link receiver: pin synchronisers, 32-bit shifter and load commit
`timescale 1ns/1ns
`include "ssrl_regs.svh"
module ssrl_serial_rx #(
    parameter int SYNC_STAGES = `SSRL_SYNC_STAGES
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // link pins
    input wire logic i_link_clk,
    input wire logic i_link_data,
    input wire logic i_load_strobe,
    // committed word
    output ssrl_pkg::ssrl_word_t o_word,
    output logic o_commit
);
    import ssrl_pkg::*;

    initial begin
        if (SYNC_STAGES != 2) begin
            $error("ssrl_serial_rx supports exactly two sync stages");
        end
    end

    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic clk_d_r;
    logic le_d_r;
    logic [`SSRL_WORD_W-1:0] shift_r;

    // meta_r feeds only sync_r; edges are found on sync_r against a delayed copy
    wire logic link_clk_s = sync_r[2];
    wire logic link_data_s = sync_r[1];
    wire logic load_s = sync_r[0];
    wire logic clk_rise = link_clk_s && !clk_d_r;
    wire logic load_rise = load_s && !le_d_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            clk_d_r <= 1'b0;
            le_d_r <= 1'b0;
        end else begin
            meta_r <= {i_link_clk, i_link_data, i_load_strobe};
            sync_r <= meta_r;
            clk_d_r <= link_clk_s;
            le_d_r <= load_s;
        end
    end

    // first bit in ends up on top after 32 shifts
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shift_r <= `SSRL_LATCH_RESET;
        end else if (clk_rise) begin
            shift_r <= {shift_r[`SSRL_WORD_W-2:0], link_data_s}; // [RL1] [RL2]
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_word <= '0;
            o_commit <= 1'b0;
        end else begin
            o_commit <= load_rise; // [RL3]
            if (load_rise) begin
                o_word <= shift_r;
            end
        end
    end

    chk_shift_msb_first: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL1] [RL2]
        clk_rise |=> shift_r == {$past(shift_r[`SSRL_WORD_W-2:0]), $past(link_data_s)})
        else $error("shift register did not take the data bit at the bottom");
    chk_commit_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL3]
        load_rise |=> o_commit && o_word == $past(shift_r) ##1 !o_commit)
        else $error("load edge did not give a single commit of the shifter");

endmodule : ssrl_serial_rx

// *** ssrl_top.sv ***
// serial synth register load: six latches, double buffering, mux out, output stage gating
//
// Functional notes
// RL1: shift one data bit into the 32-bit shifter per serial clock rising edge.
// RL2: words travel most significant bit first; first bit lands at bit 31.
// RL3: load strobe rising edge copies the shifter into exactly one latch for codes 0 to 5.
// RL4: bits 2..0 pick latch 0..5 in binary; codes 6 and 7 write nothing.
// RL5: phase, modulus, doubler, halving, R count, pump current wait for latch 0.
// RL6: host writes latch 0 after changing the modulus so it applies.
// RL7: latch 4 divider select waits for latch 0 only while latch 2 bit 13 set.
// RL8: latch 2 bits 28..26 choose which internal point drives the mux pin.
// RL9: latch 4 bits 4..3 pick one of four rising output current levels.
// RL10: with mute until lock set, output stage stays off until lock reported.
// RL11: 10-bit reference counter, 16-bit integer, 12-bit fraction and modulus.
// RL12: host keeps integer value legal for the prescaler and numerator below modulus.
// RL13: host keeps modulus in 2..4095 and reference count in 1..1023.
// RL14: zero numerator with lock detect function bit set means integer-only mode.
// RL15: host keeps load strobe low over all 32 bits, then raises it once.
`timescale 1ns/1ns
`include "ssrl_regs.svh"
module ssrl_top (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // three-wire link pins
    input wire logic i_link_clk,
    input wire logic i_link_data,
    input wire logic i_load_strobe,
    // digital lock detector, same clock
    input wire logic i_lock_detect,
    // active settings and divider state
    output ssrl_pkg::ssrl_cfg_t o_cfg,
    output logic [`SSRL_INT_W-1:0] o_n_value,
    output logic o_ref_tick,
    output logic o_integer_mode,
    // pins
    output logic o_test_mux_output,
    output logic o_out_stage_en
);
    import ssrl_pkg::*;

    function automatic logic hit(input logic [`SSRL_DEST_W-1:0] d, input logic [`SSRL_DEST_W-1:0] code);
        hit = (d == code);
    endfunction : hit

    // the latch bank as it should look once word w lands in latch d
    function automatic logic [`SSRL_NUM_LATCH-1:0][`SSRL_WORD_W-1:0] place(
        input logic [`SSRL_NUM_LATCH-1:0][`SSRL_WORD_W-1:0] a,
        input logic [`SSRL_DEST_W-1:0] d,
        input logic [`SSRL_WORD_W-1:0] w
    );
        place = a;
        place[d] = w;
    endfunction : place

    ssrl_word_t rx_word;
    logic rx_commit;
    logic [`SSRL_NUM_LATCH-1:0][`SSRL_WORD_W-1:0] lat_r;
    ssrl_dbuf_t dbuf_r;
    logic [`SSRL_DIV_W-1:0] div_r;
    logic [`SSRL_DIV_W-1:0] div_nxt;
    logic [`SSRL_RCNT_W-1:0] rcnt_r;
    logic [`SSRL_FRACTION_NUMERATOR_W-1:0] acc_r;
    logic carry_r;

    ssrl_serial_rx #(
        .SYNC_STAGES(`SSRL_SYNC_STAGES)
    ) u_rx (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_link_clk(i_link_clk),
        .i_link_data(i_link_data),
        .i_load_strobe(i_load_strobe),
        .o_word(rx_word),
        .o_commit(rx_commit)
    );

    // latch decode
    wire logic [`SSRL_WORD_W-1:0] rx_bits = rx_word;
    wire logic dest_ok = rx_word.dest <= `SSRL_DEST_L5; // [RL4]
    wire logic wr_any = rx_commit && dest_ok;
    wire logic wr0 = rx_commit && hit(rx_word.dest, `SSRL_DEST_L0);
    wire logic wr4 = rx_commit && hit(rx_word.dest, `SSRL_DEST_L4);
    wire logic [`SSRL_WORD_W-1:0] l0 = lat_r[0];
    wire logic [`SSRL_WORD_W-1:0] l1 = lat_r[1];
    wire logic [`SSRL_WORD_W-1:0] l2 = lat_r[2];
    wire logic [`SSRL_WORD_W-1:0] l4 = lat_r[4];
    wire logic dbuf_div_on = l2[`SSRL_L2_DBUF_BIT];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            lat_r <= '0;
        end else if (wr_any) begin
            lat_r[rx_word.dest] <= rx_bits; // [RL3] [RL4]
        end
    end

    // pending settings as they stand in latches 1 and 2
    wire ssrl_dbuf_t dbuf_pend = '{
        phase: l1[`SSRL_L1_PHASE_LSB +: `SSRL_FRACTION_NUMERATOR_W],
        modulus: l1[`SSRL_L1_MOD_LSB +: `SSRL_FRACTION_NUMERATOR_W],
        ref_doubler: l2[`SSRL_L2_DBL_BIT],
        ref_halve: l2[`SSRL_L2_HALF_BIT],
        ref_count: l2[`SSRL_L2_RCNT_LSB +: `SSRL_RCNT_W],
        cp_current: l2[`SSRL_L2_CP_LSB +: `SSRL_CP_W]
    };

    // latch 0 commit takes latches 1 and 2 as they were before this word
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            dbuf_r <= '0;
        end else if (wr0) begin
            dbuf_r <= dbuf_pend; // [RL5] [RL6]
        end
    end

    // divider select: immediate, or parked in latch 4 until latch 0
    wire logic [`SSRL_DIV_W-1:0] div_word = rx_bits[`SSRL_L4_DIV_LSB +: `SSRL_DIV_W];
    wire logic [`SSRL_DIV_W-1:0] div_held = l4[`SSRL_L4_DIV_LSB +: `SSRL_DIV_W];
    assign div_nxt = (wr4 && !dbuf_div_on) ? div_word : (wr0 && dbuf_div_on) ? div_held : div_r; // [RL7]

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // active settings word
    wire logic [`SSRL_FRACTION_NUMERATOR_W-1:0] fraction_numerator_now = l0[`SSRL_L0_FRACTION_NUMERATOR_LSB +: `SSRL_FRACTION_NUMERATOR_W];
    wire logic [`SSRL_INT_W-1:0] int_now = l0[`SSRL_L0_INT_LSB +: `SSRL_INT_W];
    wire logic ldf_now = l2[`SSRL_L2_LDF_BIT];
    wire logic [`SSRL_MUX_W-1:0] mux_now = l2[`SSRL_L2_MUX_LSB +: `SSRL_MUX_W];
    wire logic mute_until_lock_now = l4[`SSRL_L4_MUTE_UNTIL_LOCK_BIT];
    wire logic outen_now = l4[`SSRL_L4_OUTEN_BIT];
    wire logic int_mode_now = (fraction_numerator_now == '0) && ldf_now; // [RL14]
    wire ssrl_cfg_t cfg_nxt = '{
        int_value: int_now,
        fraction_numerator: fraction_numerator_now,
        prescaler_89: l1[`SSRL_L1_PRESC_BIT],
        dbuf: dbuf_r,
        mux_sel: mux_now,
        lock_detect_function: ldf_now,
        out_div_sel: div_r,
        out_power: l4[`SSRL_L4_PWR_LSB +: `SSRL_PWR_W],
        out_enable: outen_now,
        mute_until_lock: mute_until_lock_now
    };

    // reference divider; a zero count is illegal so it acts as one
    wire logic [`SSRL_RCNT_W-1:0] rcnt_load = (dbuf_r.ref_count == '0) ? `SSRL_RCNT_W'(1) : dbuf_r.ref_count;
    wire logic rcnt_wrap = rcnt_r <= `SSRL_RCNT_W'(1);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rcnt_r <= `SSRL_RCNT_W'(1);
            o_ref_tick <= 1'b0;
        end else begin
            rcnt_r <= rcnt_wrap ? rcnt_load : rcnt_r - `SSRL_RCNT_W'(1); // [RL11]
            o_ref_tick <= rcnt_wrap;
        end
    end

    // fraction accumulator steps once per reference tick; its carry bumps N by one
    wire logic [`SSRL_FRACTION_NUMERATOR_W:0] acc_sum = {1'b0, acc_r} + {1'b0, fraction_numerator_now};
    // a zero numerator never carries, even against an unprogrammed modulus
    wire logic acc_over = (fraction_numerator_now != '0) && (acc_sum >= {1'b0, dbuf_r.modulus});
    wire logic [`SSRL_FRACTION_NUMERATOR_W:0] acc_wrap = acc_sum - {1'b0, dbuf_r.modulus};

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            acc_r <= '0;
            carry_r <= 1'b0;
        end else if (int_mode_now) begin
            acc_r <= '0; // [RL14]
            carry_r <= 1'b0;
        end else if (o_ref_tick) begin
            acc_r <= acc_over ? acc_wrap[`SSRL_FRACTION_NUMERATOR_W-1:0] : acc_sum[`SSRL_FRACTION_NUMERATOR_W-1:0]; // [RL11]
            carry_r <= acc_over;
        end
    end

    // mux points: 0 idle low, 1 high, 2 low, 3 R divider, 4 N carry, 5 and 6 lock, 7 low
    wire logic [7:0] mux_points = {1'b0, i_lock_detect, i_lock_detect, carry_r, o_ref_tick, 1'b0, 1'b1, 1'b0};
    // mute only holds the stage off; a lost lock also drops it again
    wire logic stage_en_nxt = outen_now && (!mute_until_lock_now || i_lock_detect); // [RL10]

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_cfg <= '0;
            o_n_value <= '0;
            o_integer_mode <= 1'b0;
            o_test_mux_output <= 1'b0;
            o_out_stage_en <= 1'b0;
        end else begin
            o_cfg <= cfg_nxt; // [RL9]
            o_n_value <= int_now + `SSRL_INT_W'(carry_r); // [RL11]
            o_integer_mode <= int_mode_now; // [RL14]
            o_test_mux_output <= mux_points[mux_now]; // [RL8]
            o_out_stage_en <= stage_en_nxt; // [RL10]
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    chk_latch_written: assert property ( // [RL3] [RL4]
        rx_commit && dest_ok |=> lat_r[$past(rx_word.dest)] == $past(rx_bits))
        else $error("addressed latch did not take the word");
    chk_illegal_code: assert property ( // [RL4]
        rx_commit && !dest_ok |=> $stable(lat_r))
        else $error("codes 6 or 7 changed a latch");
    chk_one_latch: assert property ( // [RL3]
        rx_commit && dest_ok |=> lat_r == $past(place(lat_r, rx_word.dest, rx_bits)))
        else $error("a latch other than the addressed one changed");
    chk_pend_holds: assert property ( // [RL5]
        !wr0 |=> $stable(dbuf_r))
        else $error("buffered settings moved without a latch 0 write");
    chk_pend_applies: assert property ( // [RL5]
        wr0 |=> dbuf_r.modulus == $past(l1[`SSRL_L1_MOD_LSB +: `SSRL_FRACTION_NUMERATOR_W]) &&
            dbuf_r.ref_count == $past(l2[`SSRL_L2_RCNT_LSB +: `SSRL_RCNT_W]) ##1
            o_cfg.dbuf == $past(dbuf_r))
        else $error("latch 0 write did not apply pending settings");
    chk_div_direct: assert property ( // [RL7]
        wr4 && !dbuf_div_on |=> ##1 o_cfg.out_div_sel == $past(div_word, 2))
        else $error("divider select not applied at once");
    chk_div_parked: assert property ( // [RL7]
        wr4 && dbuf_div_on && !wr0 |=> div_r == $past(div_r))
        else $error("buffered divider select applied early");
    chk_mux_route: assert property ( // [RL8]
        ##1 o_test_mux_output == $past(mux_points[l2[`SSRL_L2_MUX_LSB +: `SSRL_MUX_W]]))
        else $error("mux pin does not follow the selected point");
    chk_power_field: assert property ( // [RL9]
        ##1 o_cfg.out_power == $past(l4[`SSRL_L4_PWR_LSB +: `SSRL_PWR_W]))
        else $error("output power does not follow latch 4 bits 4..3");
    chk_mute_lock: assert property ( // [RL10]
        mute_until_lock_now && !i_lock_detect |=> !o_out_stage_en)
        else $error("output stage enabled before lock");
    chk_int_mode: assert property ( // [RL14]
        ##1 o_integer_mode == $past(fraction_numerator_now == '0 && ldf_now))
        else $error("integer mode flag wrong");
    chk_ref_period: assert property ( // [RL11]
        o_ref_tick && $stable(dbuf_r) |-> rcnt_r == rcnt_load)
        else $error("reference counter reload wrong");

    cov_write_l0: cover property (wr0);
    cov_div_parked: cover property (wr4 && dbuf_div_on ##[1:1000] wr0);
    cov_mute_release: cover property (mute_until_lock_now && !o_out_stage_en ##1 o_out_stage_en);
    cov_illegal_code: cover property (rx_commit && !dest_ok);

endmodule : ssrl_top

// *** ssrl_host_model.sv ***
// host controller model driving the three-wire programming link
`timescale 1ns/1ns
module ssrl_host_model (
    // clock
    input wire logic i_ref_clk,
    // link pins
    output logic o_link_clk,
    output logic o_link_data,
    output logic o_load_strobe
);
    initial begin
        o_link_clk = 1'b0;
        o_link_data = 1'b0;
        o_load_strobe = 1'b0;
    end

    // half = ref cycles per link clock low level, high lasts one more; 4 gives a 360 ns period
    task automatic send_word(input logic [31:0] w, input int half);
        for (int i = 31; i >= 0; i--) begin
            @(posedge i_ref_clk);
            o_link_data <= w[i];
            o_link_clk <= 1'b0;
            repeat (half) @(posedge i_ref_clk);
            o_link_clk <= 1'b1;
            repeat (half) @(posedge i_ref_clk);
        end
        o_link_clk <= 1'b0;
        repeat (half) @(posedge i_ref_clk);
        // strobe low over all bits, one rise after the last edge
        o_load_strobe <= 1'b1;
        // no pull on data: show the inverse once released
        o_link_data <= ~w[0];
        repeat (half) @(posedge i_ref_clk);
        o_load_strobe <= 1'b0;
    endtask : send_word
endmodule : ssrl_host_model

// *** serial_synth_register_load_tb.sv ***
// self-checking bench for the serial synth register load block
`timescale 1ns/1ns
`include "ssrl_regs.svh"
module serial_synth_register_load_tb;
    import ssrl_pkg::*;
    typedef struct packed {
        ssrl_cfg_t cfg;
        logic mux;
        logic en;
        logic imode;
    } ssrl_note_t;

    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic lock_detect = 1'b0;
    logic link_clk, link_data, load_strobe, ref_tick, imode, mux_out, stage_en;
    ssrl_cfg_t cfg;
    logic [`SSRL_INT_W-1:0] n_value;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    ssrl_note_t notes[$];
    event chk_ev;
    ssrl_cfg_t exp_cfg;
    ssrl_dbuf_t pend;
    logic dbuf_div, parked, lock;
    logic [2:0] pend_div;
    logic [31:0] seed = 32'h84C1;
    logic [31:0] r;

    always #20 i_ref_clk = ~i_ref_clk;

    ssrl_host_model i_ssrl_host_model (.i_ref_clk(i_ref_clk), .o_link_clk(link_clk),
        .o_link_data(link_data), .o_load_strobe(load_strobe));

    ssrl_top i_ssrl_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_link_clk(link_clk),
        .i_link_data(link_data), .i_load_strobe(load_strobe), .i_lock_detect(lock_detect),
        .o_cfg(cfg), .o_n_value(n_value), .o_ref_tick(ref_tick), .o_integer_mode(imode),
        .o_test_mux_output(mux_out), .o_out_stage_en(stage_en));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // wait for outputs to settle, then note the expectation
    task automatic settle();
        ssrl_note_t n;
        repeat (12) @(posedge i_ref_clk);
        n.cfg = exp_cfg;
        n.mux = (exp_cfg.mux_sel == 3'h1) || ((exp_cfg.mux_sel inside {3'h5, 3'h6}) && lock);
        n.en = exp_cfg.out_enable && (!exp_cfg.mute_until_lock || lock);
        n.imode = (exp_cfg.fraction_numerator == 12'h000) && exp_cfg.lock_detect_function;
        notes.push_back(n);
        -> chk_ev;
    endtask : settle

    task automatic put(input logic [31:0] w, input int half);
        i_ssrl_host_model.send_word(w, half);
        case (w[2:0])
            3'h0: begin
                exp_cfg.int_value = w[30:15];
                exp_cfg.fraction_numerator = w[14:3];
                exp_cfg.dbuf = pend;
                if (parked) exp_cfg.out_div_sel = pend_div;
                parked = 1'b0;
            end
            3'h1: begin
                exp_cfg.prescaler_89 = w[27];
                pend.phase = w[26:15];
                pend.modulus = w[14:3];
            end
            3'h2: begin
                exp_cfg.mux_sel = w[28:26];
                pend.ref_doubler = w[25];
                pend.ref_halve = w[24];
                pend.ref_count = w[23:14];
                dbuf_div = w[13];
                pend.cp_current = w[11:9];
                exp_cfg.lock_detect_function = w[8];
            end
            3'h4: begin
                if (dbuf_div) begin
                    pend_div = w[22:20];
                    parked = 1'b1;
                end else exp_cfg.out_div_sel = w[22:20];
                exp_cfg.mute_until_lock = w[10];
                exp_cfg.out_enable = w[5];
                exp_cfg.out_power = w[4:3];
            end
            default: ;
        endcase
        settle();
    endtask : put

    task automatic set_lock(input logic v);
        @(posedge i_ref_clk);
        lock_detect <= v;
        lock = v;
        settle();
    endtask : set_lock

    initial begin
        ssrl_note_t n;
        forever begin
            @(chk_ev);
            n = notes.pop_front();
            check(cfg, n.cfg, "active settings");
            check(mux_out, n.mux, "mux pin");
            check(stage_en, n.en, "output stage enable");
            check(imode, n.imode, "integer mode");
            if (n.cfg.fraction_numerator === 12'h000) begin
                check(n_value, n.cfg.int_value, "n value");
            end
        end
    end

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        exp_cfg = '0;
        pend = '0;
        dbuf_div = 1'b0;
        parked = 1'b0;
        lock = 1'b0;
        pend_div = 3'h0;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        settle();
        // modulus parked until latch 0; legal host values only
        put({4'h0, 1'b1, 12'h5A3, 12'hFFF, 3'h1}, 4);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            r = seed;
            // latch 0 written after the modulus change
            put({1'b0, 16'd75 + {1'b0, r[30:16]}, r[14:4], 1'b0, 3'h0}, 4);
        end
        seed = xs(seed);
        put({3'h0, 3'h1, 2'b10, seed[9:0] | 10'h001, 1'b0, 1'b0, 3'h5, 1'b1, 5'h00, 3'h2}, 4);
        put({1'b0, 16'd75, 12'h000, 3'h0}, 4);
        for (int j = 0; j < 6; j++) begin
            set_lock(j[0]);
            put({3'h0, 3'(j < 3 ? j : j + 2), 17'h00000, 1'b1, 5'h00, 3'h2}, 4);
        end
        for (int p = 0; p < 4; p++) begin
            put({9'h000, 3'(p), 14'h0000, 1'b1, 2'(p), 3'h4}, 4);
        end
        set_lock(1'b0);
        put({9'h000, 3'h2, 9'h000, 1'b1, 4'h0, 1'b1, 2'h3, 3'h4}, 4);
        set_lock(1'b1);
        set_lock(1'b0);
        put({3'h0, 3'h1, 2'h0, 10'h001, 1'b1, 1'b0, 3'h2, 1'b1, 5'h00, 3'h2}, 4);
        put({9'h000, 3'h5, 14'h0000, 1'b1, 2'h1, 3'h4}, 4);
        put({1'b0, 16'd100, 12'h000, 3'h0}, 4);
        for (int d = 6; d < 8; d++) begin
            seed = xs(seed);
            put({seed[28:0], 3'(d)}, 4);
        end
        summarize();
    end
endmodule : serial_synth_register_load_tb
